// >>> rtl/lpd_pkg.sv
// constants and types for the led pwm dimming pre-boost control
// Operation
// - sinks on when enable and pwm high
// - either low turns sinks off, core runs
// - pwm high pulses down to 300 ns honoured
// - short pulses may repeatedly flag overvoltage fault
// - host ignores fault below 500 ns pulses
// - host keeps pwm low at least 1 us
// - host may hold pwm permanently high
// - rising edge: boost now, sinks after delay
// - falling edge: both stay on for delay
// - delay length comes from external setting
// - delay about three switching cycles recommended
// - peak current scalable from 10 to 100 percent
// - voltage mode uses 0.2 to 2 V level
// - clock mode uses dimming clock duty cycle
// - clock activity enters clock dimming mode
// - 50 us without clock reverts to voltage
// - dimming clock phases at least 150 ns
// - dim level equals 100 percent minus duty
package lpd_pkg;
	localparam int CLK_NS = 50;
	localparam int NUM_SINKS = 6;
	localparam int DELAY_W = 10;
	localparam int DIM_W = 8;
	localparam int MIN_PULSE_NS = 300;
	localparam int SHORT_PULSE_NS = 500;
	localparam int MIN_LOW_NS = 1000;
	localparam int CLK_TIMEOUT_NS = 50000;
	localparam int CLK_PHASE_NS = 150;
	localparam int SHORT_PULSE_CYC = SHORT_PULSE_NS / CLK_NS;
	localparam int MIN_LOW_CYC = (MIN_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int CLK_TIMEOUT_CYC = CLK_TIMEOUT_NS / CLK_NS;
	localparam int CLK_PHASE_CYC = (CLK_PHASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMO_W = 10;
	localparam int PER_W = 12;
	// dim code 255 is full scale, 25 is about 10 percent
	localparam logic [DIM_W-1:0] DIM_FULL = 8'hff;
	localparam logic [DIM_W-1:0] DIM_MIN = 8'h19;
	localparam logic [DIM_W-1:0] DIM_RST = 8'hff;
	localparam logic [DELAY_W-1:0] DELAY_RST = 10'h000;
	typedef enum logic [1:0] {
		PB_OFF = 2'b00,
		PB_PRE = 2'b01,
		PB_ON = 2'b11,
		PB_POST = 2'b10
	} lpd_pb_state_type;
endpackage

// >>> rtl/lpd_if.sv
// link between host controller and dimming control
`timescale 1ns/1ns
interface lpd_if;
	import lpd_pkg::*;
	logic                 enable;
	logic                 pwm;
	logic                 dim_clk;
	logic [DIM_W-1:0]     dim_voltage;
	logic [DELAY_W-1:0]   pre_boost_delay_pin;
	logic [NUM_SINKS-1:0] sink_select;
	logic                 fault_n;
	modport device (
		input  enable, pwm, dim_clk, dim_voltage,
		input  pre_boost_delay_pin, sink_select,
		output fault_n
	);
	modport host (
		output enable, pwm, dim_clk, dim_voltage,
		output pre_boost_delay_pin, sink_select,
		input  fault_n
	);
endinterface

// >>> rtl/lpd_clock_dim.sv
// clock duty dimming detector and dim level select
`timescale 1ns/1ns
module lpd_clock_dim
	import lpd_pkg::*;
(
	input  wire logic             clock_i,
	input  wire logic             reset_n_i,
	input  wire logic             dim_clk_i,
	input  wire logic [DIM_W-1:0] dim_voltage_i,
	output logic                  clock_duty_dim_mode_o,
	output logic [DIM_W-1:0]      dim_level_o
);
	logic             s1_q, s2_q, s3_q;
	logic             mode_q, mode_d;
	logic [TMO_W-1:0] tmo_q, tmo_d;
	logic [PER_W-1:0] per_q, per_d, hi_q, hi_d;
	logic [DIM_W-1:0] lvl_q, lvl_d;
	logic [PER_W+DIM_W-1:0] prod;
	logic [DIM_W-1:0] duty;
	logic             rise;

	assign rise = s2_q & ~s3_q;
	assign prod = {hi_q, {DIM_W{1'b0}}} / ({{DIM_W{1'b0}}, per_q} + 1'b1);
	assign duty = (prod > {{PER_W{1'b0}}, DIM_FULL}) ? DIM_FULL
		: prod[DIM_W-1:0];

	always_comb begin
		mode_d = mode_q;
		tmo_d = tmo_q;
		per_d = per_q;
		hi_d = hi_q;
		lvl_d = lvl_q;
		if (rise) begin
			mode_d = 1'b1;
			tmo_d = '0;
			per_d = '0;
			// the rising cycle is already a high cycle of the period
			hi_d = {{(PER_W-1){1'b0}}, 1'b1};
			// level falls as duty rises
			if (mode_q)
				lvl_d = DIM_FULL - duty;
		end else begin
			if (per_q != {PER_W{1'b1}})
				per_d = per_q + 1'b1;
			if (s2_q && hi_q != {PER_W{1'b1}})
				hi_d = hi_q + 1'b1;
			if (tmo_q == TMO_W'(CLK_TIMEOUT_CYC - 1))
				mode_d = 1'b0;
			else
				tmo_d = tmo_q + 1'b1;
		end
		if (!mode_d)
			lvl_d = dim_voltage_i;
		if (lvl_d < DIM_MIN)
			lvl_d = DIM_MIN;
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			mode_q <= 1'b0;
			tmo_q <= '0;
			per_q <= '0;
			hi_q <= '0;
			lvl_q <= DIM_RST;
		end else begin
			s1_q <= dim_clk_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			mode_q <= mode_d;
			tmo_q <= tmo_d;
			per_q <= per_d;
			hi_q <= hi_d;
			lvl_q <= lvl_d;
		end
	end

	assign clock_duty_dim_mode_o = mode_q;
	assign dim_level_o = lvl_q;
endmodule

// >>> rtl/lpd_device.sv
// dimming control end: pre-boost sequencing, sinks, boost, fault
`timescale 1ns/1ns
module lpd_device
	import lpd_pkg::*;
(
	input  wire logic                  clock_i,
	input  wire logic                  reset_n_i,
	lpd_if.device                      link,
	input  wire logic                  over_voltage_i,
	output logic [NUM_SINKS-1:0]       sink_on_o,
	output logic                       boost_on_o,
	output logic                       clock_duty_dim_mode_o,
	output logic [DIM_W-1:0]           dim_level_o
);
	import lpd_pkg::*;
	logic                 en1_q, en2_q, pw1_q, pw2_q;
	logic                 gate;
	lpd_pb_state_type     st_q, st_d;
	logic [DELAY_W-1:0]   cnt_q, cnt_d;
	logic [NUM_SINKS-1:0] sink_q, sink_d;
	logic                 boost_q, boost_d, fault_q, fault_d;
	logic                 mode_w;
	logic [DIM_W-1:0]     lvl_w;
	logic                 mode_q;
	logic [DIM_W-1:0]     lvl_q;

	assign gate = en2_q & pw2_q;

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		// delay loaded from the programming pin
		case (st_q)
			PB_OFF: begin
				if (gate) begin
					cnt_d = link.pre_boost_delay_pin;
					st_d = (link.pre_boost_delay_pin == '0) ? PB_ON : PB_PRE;
				end
			end
			PB_PRE: begin
				if (cnt_q <= 10'h001)
					st_d = PB_ON;
				else
					cnt_d = cnt_q - 1'b1;
				if (!gate) begin
					// end early pulse after same delay
					cnt_d = link.pre_boost_delay_pin;
					st_d = (link.pre_boost_delay_pin == '0) ? PB_OFF
						: PB_POST;
				end
			end
			PB_ON: begin
				if (!gate) begin
					cnt_d = link.pre_boost_delay_pin;
					st_d = (link.pre_boost_delay_pin == '0) ? PB_OFF
						: PB_POST;
				end
			end
			PB_POST: begin
				if (cnt_q <= 10'h001)
					st_d = gate ? PB_PRE : PB_OFF;
				else
					cnt_d = cnt_q - 1'b1;
				if (cnt_q <= 10'h001 && gate)
					cnt_d = link.pre_boost_delay_pin;
			end
			default: st_d = PB_OFF;
		endcase
		// sinks follow delayed pwm, boost is pwm or delayed pwm
		sink_d = (st_d == PB_ON || st_d == PB_POST)
			? link.sink_select : '0;
		boost_d = gate | (st_d != PB_OFF);
		// flag follows the registered boost, one cycle behind
		fault_d = ~(over_voltage_i & boost_q);
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			en1_q <= 1'b0;
			en2_q <= 1'b0;
			pw1_q <= 1'b0;
			pw2_q <= 1'b0;
			st_q <= PB_OFF;
			cnt_q <= DELAY_RST;
			sink_q <= '0;
			boost_q <= 1'b0;
			fault_q <= 1'b1;
			mode_q <= 1'b0;
			lvl_q <= DIM_RST;
		end else begin
			en1_q <= link.enable;
			en2_q <= en1_q;
			pw1_q <= link.pwm;
			pw2_q <= pw1_q;
			st_q <= st_d;
			cnt_q <= cnt_d;
			sink_q <= sink_d;
			boost_q <= boost_d;
			fault_q <= fault_d;
			mode_q <= mode_w;
			lvl_q <= lvl_w;
		end
	end

	lpd_clock_dim u_dim (
		.clock_i               (clock_i),
		.reset_n_i             (reset_n_i),
		.dim_clk_i             (link.dim_clk),
		.dim_voltage_i         (link.dim_voltage),
		.clock_duty_dim_mode_o (mode_w),
		.dim_level_o           (lvl_w)
	);

	assign link.fault_n = fault_q;
	assign sink_on_o = sink_q;
	assign boost_on_o = boost_q;
	assign clock_duty_dim_mode_o = mode_q;
	assign dim_level_o = lvl_q;
endmodule

// >>> rtl/lpd_host.sv
// host end: drives enable, pwm, dimming clock and watches fault
`timescale 1ns/1ns
module lpd_host
	import lpd_pkg::*;
(
	input  wire logic                  clock_i,
	input  wire logic                  reset_n_i,
	lpd_if.host                        link,
	input  wire logic                  enable_i,
	input  wire logic                  pwm_req_i,
	input  wire logic                  dim_clk_i,
	input  wire logic [DIM_W-1:0]      dim_voltage_i,
	input  wire logic [DELAY_W-1:0]    delay_i,
	input  wire logic [NUM_SINKS-1:0]  sink_select_i,
	output logic                       fault_seen_o
);
	logic                 pwm_q, pwm_d;
	logic [4:0]           low_q, low_d, hi_q, hi_d;
	logic                 fault_q, fault_d;
	logic                 en_q, dclk_q;
	logic [DIM_W-1:0]     dv_q;
	logic [DELAY_W-1:0]   dl_q;
	logic [NUM_SINKS-1:0] ss_q;

	always_comb begin
		pwm_d = pwm_q;
		low_d = low_q;
		hi_d = hi_q;
		// pwm may stay high forever; low held a minimum time
		if (pwm_q) begin
			if (!pwm_req_i) begin
				pwm_d = 1'b0;
				low_d = '0;
			end
			if (hi_q != 5'h1f)
				hi_d = hi_q + 1'b1;
		end else begin
			if (low_q != 5'h1f)
				low_d = low_q + 1'b1;
			if (pwm_req_i && low_q >= 5'(MIN_LOW_CYC - 1)) begin
				pwm_d = 1'b1;
				hi_d = '0;
			end
		end
		// fault ignored during short pulses
		fault_d = ~link.fault_n
			& ~(hi_q < 5'(SHORT_PULSE_CYC));
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pwm_q <= 1'b0;
			low_q <= 5'h1f;
			hi_q <= 5'h1f;
			fault_q <= 1'b0;
			en_q <= 1'b0;
			dclk_q <= 1'b0;
			dv_q <= DIM_RST;
			dl_q <= DELAY_RST;
			ss_q <= '0;
		end else begin
			pwm_q <= pwm_d;
			low_q <= low_d;
			hi_q <= hi_d;
			fault_q <= fault_d;
			en_q <= enable_i;
			dclk_q <= dim_clk_i;
			dv_q <= dim_voltage_i;
			dl_q <= delay_i;
			ss_q <= sink_select_i;
		end
	end

	assign link.enable = en_q;
	assign link.pwm = pwm_q;
	assign link.dim_clk = dclk_q;
	assign link.dim_voltage = dv_q;
	assign link.pre_boost_delay_pin = dl_q;
	assign link.sink_select = ss_q;
	assign fault_seen_o = fault_q;
endmodule

// >>> verification/lpd_props.sv
// link assertions for the pre-boost dimming control
`timescale 1ns/1ns
module lpd_props (
	input wire logic                          clock_i,
	input wire logic                          reset_n_i,
	input wire logic                          enable,
	input wire logic                          pwm,
	input wire logic                          dim_clk,
	input wire logic [lpd_pkg::DELAY_W-1:0]   pre_boost_delay_pin,
	input wire logic [lpd_pkg::NUM_SINKS-1:0] sink_select,
	input wire logic                          fault_n,
	input wire logic                          over_voltage_i,
	input wire logic [lpd_pkg::NUM_SINKS-1:0] sink_on_o,
	input wire logic                          boost_on_o,
	input wire logic                          clock_duty_dim_mode_o
);
	import lpd_pkg::*;
	logic        gate;
	logic        dc_q;
	logic [11:0] dly;
	logic [11:0] hi_q, hi_d, lo_q, lo_d, qt_q, qt_d, on_q, on_d, len_q, len_d;
	assign gate = enable & pwm;
	assign dly = 12'(pre_boost_delay_pin);
	// saturating run lengths of gate, sinks and dim clock silence
	always_comb begin
		hi_d = gate ? hi_q + 12'(~&hi_q) : 12'h000;
		lo_d = gate ? 12'h000 : lo_q + 12'(~&lo_q);
		on_d = (|sink_on_o) ? on_q + 12'(~&on_q) : 12'h000;
		qt_d = (dim_clk & ~dc_q) ? 12'h000 : qt_q + 12'(~&qt_q);
		len_d = (!gate && hi_q != 12'h000) ? hi_q : len_q;
	end
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			{hi_q, lo_q, on_q, qt_q, len_q} <= '0;
			dc_q <= 1'b0;
		end else begin
			{hi_q, lo_q, on_q, qt_q, len_q} <= {hi_d, lo_d, on_d, qt_d, len_d};
			dc_q <= dim_clk;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_sink_rise;
		$rose(|sink_on_o) && gate;
	endsequence
	a_boost_rise_lat: assert property ($rose(boost_on_o) |-> hi_q == 12'h003)
		else $error("boost start latency wrong");
	a_boost_fall_lat: assert property ($fell(boost_on_o) |-> lo_q == dly + 12'h003)
		else $error("boost hold after pwm fall wrong");
	a_sink_pre_delay: assert property (s_sink_rise |-> hi_q == dly + 12'h003)
		else $error("sinks not delayed by pre-boost time");
	a_on_time_kept: assert property ($fell(|sink_on_o) && len_q > dly |-> on_q == len_q)
		else $error("sink on-time differs from pwm high time");
	a_sink_select: assert property ((|sink_on_o) |-> sink_on_o == sink_select)
		else $error("sinks differ from selection");
	a_sink_in_boost: assert property ((|sink_on_o) |-> boost_on_o)
		else $error("sinks on without boost");
	a_idle_all_off: assert property (lo_q > dly + 12'h003 |-> !boost_on_o && sink_on_o == '0)
		else $error("sinks or boost on while gated off");
	a_fault_flag_low: assert property (over_voltage_i && boost_on_o |=> !fault_n)
		else $error("overvoltage not flagged");
	a_fault_idle_high: assert property (!boost_on_o |=> fault_n)
		else $error("fault flagged without boost");
	a_clk_mode_entry: assert property ($rose(dim_clk) |-> ##[1:6] clock_duty_dim_mode_o)
		else $error("clock dimming mode not entered");
	a_clk_mode_exit: assert property (qt_q > 12'(CLK_TIMEOUT_CYC + 8) |-> !clock_duty_dim_mode_o)
		else $error("clock dimming mode not left");
endmodule

// >>> verification/led_pwm_dimming_preboost_bench.sv
// bench joining host and dimming control over the link
`timescale 1ns/1ns
module led_pwm_dimming_preboost_bench;
	import lpd_pkg::*;
	typedef struct packed {
		logic               en;
		logic               ov;
		logic [DELAY_W-1:0] dly;
		logic [7:0]         high;
		logic [5:0]         sel;
	} lpd_row_type;
	logic                 clock_i, reset_n_i, enable_i, pwm_req_i, dim_clk_i;
	logic                 over_voltage_i, fault_seen_o, boost_on_o, mode_o;
	logic [DIM_W-1:0]     dim_voltage_i, dim_level_o;
	logic [DELAY_W-1:0]   delay_i;
	logic [NUM_SINKS-1:0] sink_select_i, sink_on_o;
	int                   failures, total_checks;
	lpd_row_type          rows [6] = '{
		'{1'b1, 1'b1, 10'h005, 8'h14, 6'h3f}, '{1'b1, 1'b0, 10'h000, 8'h0a, 6'h01},
		'{1'b1, 1'b1, 10'h004, 8'h06, 6'h2a}, '{1'b0, 1'b0, 10'h005, 8'h14, 6'h3f},
		'{1'b1, 1'b0, 10'h028, 8'h64, 6'h15}, '{1'b1, 1'b0, 10'h008, 8'h09, 6'h3c}};
	lpd_if link ();
	lpd_host lpd_host_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.link(link.host), .enable_i(enable_i), .pwm_req_i(pwm_req_i),
		.dim_clk_i(dim_clk_i), .dim_voltage_i(dim_voltage_i), .delay_i(delay_i),
		.sink_select_i(sink_select_i), .fault_seen_o(fault_seen_o));
	lpd_device lpd_device_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.link(link.device), .over_voltage_i(over_voltage_i),
		.sink_on_o(sink_on_o), .boost_on_o(boost_on_o),
		.clock_duty_dim_mode_o(mode_o), .dim_level_o(dim_level_o));
	lpd_props lpd_props_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.enable(link.enable), .pwm(link.pwm), .dim_clk(link.dim_clk),
		.pre_boost_delay_pin(link.pre_boost_delay_pin),
		.sink_select(link.sink_select), .fault_n(link.fault_n),
		.over_voltage_i(over_voltage_i), .sink_on_o(sink_on_o),
		.boost_on_o(boost_on_o), .clock_duty_dim_mode_o(mode_o));
	always #25 clock_i = ~clock_i;
	task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_cnt({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#5;
	endtask
	task automatic conclude();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// one pwm pulse, counting sink and boost cycles
	task automatic run_row(input lpd_row_type r);
		int   sn, bo, h, d;
		logic fs;
		sn = 0; bo = 0; fs = 1'b0; h = int'(r.high); d = int'(r.dly);
		{enable_i, over_voltage_i, delay_i, sink_select_i} = {r.en, r.ov, r.dly, r.sel};
		tick(30);
		for (int i = 0; i < h + d + 20; i++) begin
			pwm_req_i = (i < h);
			tick(1);
			sn += int'(sink_on_o === r.sel);
			bo += int'(boost_on_o === 1'b1);
			fs |= fault_seen_o;
		end
		over_voltage_i = 1'b0;
		chk_cnt(16'(sn), r.en ? 16'(h) : 16'h0000);
		chk_cnt(16'(bo), r.en ? 16'(h + d) : 16'h0000);
		chk_bit(fs, r.en & r.ov & (h >= 10));
	endtask
	initial begin
		{clock_i, reset_n_i, enable_i, pwm_req_i, dim_clk_i, over_voltage_i} = '0;
		{delay_i, sink_select_i} = '0;
		dim_voltage_i = 8'hff;
		failures = 0;
		total_checks = 0;
		repeat (4) @(posedge clock_i);
		#5 reset_n_i = 1'b1;
		chk_cnt({sink_on_o, boost_on_o, link.fault_n, mode_o}, 16'h0002);
		chk_cnt(16'(dim_level_o), 16'h00ff);
		foreach (rows[k]) run_row(rows[k]);
		dim_voltage_i = 8'h80;
		tick(5);
		chk_cnt({mode_o, dim_level_o}, 16'h0080);
		for (int p = 0; p < 20; p++) begin
			dim_clk_i = 1'b1;
			tick(3);
			dim_clk_i = 1'b0;
			tick(7);
		end
		chk_bit(mode_o, 1'b1);
		chk_cnt(16'(dim_level_o), 16'(255 - (256 * 3) / 10));
		tick(CLK_TIMEOUT_CYC + 10);
		chk_cnt({mode_o, dim_level_o}, 16'h0080);
		conclude();
	end
endmodule
